// ### sabr_alu_slide.sv
// sabr_alu_slide.sv: state machine placing the alu point in address, cache or memory
// assumes: group flags are valid with grp.vld; miss is the same-cycle mispredict
`timescale 1ns/1ps
`include "sabr_defs.svh"

module sabr_alu_slide import sabr_pkg::*; (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       hold,
  input  wire logic       miss,
  input  wire sabr_grp_t  grp,
  input  wire logic       twoIdle,
  output sabr_xloc_t      loc,
  output sabr_xloc_t      nextLoc
);

  sabr_sld_t st;
  sabr_sld_t nxt;
  logic      needM;
  logic      issue;

  // a same-group load use, or a special move in a group without a compare, pushes to memory; compares never do
  assign needM = grp.loadUseSame || (grp.sprMove && !grp.cmpRec);
  assign issue = grp.vld && grp.aluUse && !hold && !miss;

  always_comb begin
    nxt = st;
    if (miss) begin
      nxt.loc = SABR_X_A;
    end else if (hold) begin
      nxt.loc = st.loc;
    end else if (issue) begin
      // only ever later while the alu stays busy
      if (needM) begin
        nxt.loc = SABR_X_M;
      end else if (grp.loadUsePrev && st.loc == SABR_X_A) begin
        nxt.loc = SABR_X_C;
      end else begin
        nxt.loc = st.loc;
      end
    end else begin
      // alu idle this cycle: step back toward address
      case (st.loc)
        SABR_X_M: nxt.loc = twoIdle ? SABR_X_A : SABR_X_C;
        SABR_X_C: nxt.loc = SABR_X_A;
        SABR_X_A: nxt.loc = SABR_X_A;
        default:  nxt.loc = SABR_X_A;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st.loc <= SABR_X_A;
    end else begin
      st <= nxt;
    end
  end

  assign loc     = st.loc;
  assign nextLoc = nxt.loc;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence sIdle;
    !hold && !miss && !(grp.vld && grp.aluUse);
  endsequence

  AST_X_ONEHOT: assert property ($onehot(loc))
    else $error("alu point not one-hot");
  AST_LOAD_PREV: assert property (issue && grp.loadUsePrev && !needM && loc == SABR_X_A
    |=> loc == SABR_X_C)
    else $error("load use of previous group did not move alu to cache");
  AST_LOAD_SAME: assert property (issue && grp.loadUseSame |=> loc == SABR_X_M)
    else $error("same-group load use did not move alu to memory");
  AST_SPR_OUT: assert property (issue && grp.sprMove && !grp.cmpRec
    |=> loc == SABR_X_M)
    else $error("special move did not move alu to memory");
  AST_CMP_STAY: assert property (issue && grp.cmpRec && !grp.loadUseSame && !grp.loadUsePrev
    && loc == SABR_X_A |=> loc == SABR_X_A)
    else $error("compare forced the alu point out");
  AST_STAY_LATE: assert property (issue && loc == SABR_X_M ##1 issue |=> loc == SABR_X_M)
    else $error("busy alu left memory");
  AST_STEP_BACK: assert property (sIdle ##0 (loc == SABR_X_C) |=> loc == SABR_X_A)
    else $error("idle alu did not return from cache");
  AST_TWO_BACK: assert property (sIdle ##0 (loc == SABR_X_M) |=>
    (loc == ($past(twoIdle) ? SABR_X_A : SABR_X_C)))
    else $error("idle alu stepped back wrongly from memory");
  AST_MISS_HOME: assert property (miss |=> loc == SABR_X_A)
    else $error("mispredict did not return alu to address");

endmodule // sabr_alu_slide

// ### sabr_defs.svh
// sabr_defs.svh: sizes, stage indices and limits of the sliding alu and branch resolve block
// assumes: included by bare name from every sabr file; definitions only
`ifndef SABR_DEFS_SVH
`define SABR_DEFS_SVH

`define SABR_PCW     32 // fetch address width
`define SABR_NSTG    4  // tracked stages: address, cache, memory, writeback
`define SABR_NBR     2  // branch slots per issued group
`define SABR_ST_A    0  // address stage index
`define SABR_ST_C    1  // cache stage index
`define SABR_ST_M    2  // memory stage index
`define SABR_ST_W    3  // writeback stage index
`define SABR_ST_GONE 4  // first position past writeback
`define SABR_PEN_MIN 2  // mispredict penalty in cycles when the flag is known in address
`define SABR_PEN_MAX 5  // mispredict penalty in cycles with the alu point in memory

`endif

// ### sabr_fetch_model.sv
// sabr_fetch_model.sv: fetch and decode stand-in that offers issue groups and takes redirects
// assumes: the bench loads reqGrp before each falling edge; one group is offered per cycle
`timescale 1ns/1ps
`include "sabr_defs.svh"

module sabr_fetch_model import sabr_pkg::*; (
  input  wire logic            sys_clk,
  input  wire sabr_redir_t     redirect,
  input  wire logic            rst_b,
  input  wire sabr_grp_t       reqGrp,
  output sabr_grp_t            issueGrp,
  output logic [`SABR_PCW-1:0] fetchPc
);
  // groups change at the falling edge so the block samples them settled;
  // a group is shown for one cycle only, so a refused one is simply lost
  always @(negedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      issueGrp <= '0;
      fetchPc  <= '0;
    end else begin
      issueGrp <= reqGrp;
      if (redirect.vld) fetchPc <= redirect.pc; // refetch address
    end
  end
endmodule // sabr_fetch_model

// ### sabr_pipe_ctrl.sv
// sabr_pipe_ctrl.sv: tracks issued groups through address, cache, memory and writeback,
// places the sliding alu point and resolves branches oldest first
// assumes: decode drives one group per cycle; fetch and decode stages live outside;
// condTrue carries each tracked branch's condition, valid once its flag is ready
//
// Summary of operation
// - flows go fetch, decode, address, cache, memory, writeback, one stage per cycle
// - a group moves in lockstep; any stall holds the whole group in place
// - alu point can sit in address, cache or memory; starts in address
// - load data ready after cache; next-cycle consumer moves alu to cache
// - load and consumer in one group move alu to memory
// - special register or whole condition moves push alu to memory; the code skips the push when the group also sets cmpRec
// - compares and record_bit updates of first two fields do not push alu out
// - alu point stays late while the alu keeps being used
// - group without alu steps the point back one stage
// - two alu-free flows may bring it from memory straight to address
// - any mispredict returns the alu point to address at once
// - mispredict found no earlier than the cycle after its flag; penalty two to five
// - resolve checks direction and target; mismatch flushes and redirects fetch
// - every stage holds unresolved branches in any slot with own prediction
// - unconditional branches resolve to check target without waiting for a flag
// - stale flag branches resolve in address; others the stage after the flag
// - one branch resolved per cycle, always the oldest; younger ones wait
// - alu flags are ready the cycle after the alu stage
// - condition logical results are not ready before writeback
// - count branch after an explicit count load waits past that load's writeback
`timescale 1ns/1ps
`include "sabr_defs.svh"

module sabr_pipe_ctrl import sabr_pkg::*; (
  input  wire logic                                sys_clk,
  input  wire logic                                rst_b,
  input  wire logic                                stall,
  input  wire sabr_grp_t                           issueGrp,
  input  wire logic                                nextTwoNoAlu,
  input  wire logic [`SABR_NSTG*`SABR_NBR-1:0]     condTrue,
  output sabr_stg_t [`SABR_NSTG-1:0]               pipeStages,
  output sabr_xloc_t                               xLoc,
  output logic                                     flush,
  output sabr_redir_t                              redirect,
  output logic                                     resolveVld,
  output logic                                     resolveMiss
);

  sabr_ctl_t  st;
  sabr_ctl_t  nxt;
  sabr_xloc_t nextLoc;
  logic       fnd;
  logic       rdy;
  logic       resNow;
  logic       missNow;
  logic       taken;
  int         selS;
  int         selB;
  sabr_br_t   selBr;

  // stage index of an alu position
  function automatic int xIdx(input sabr_xloc_t loc);
    case (loc)
      SABR_X_A: xIdx = `SABR_ST_A;
      SABR_X_C: xIdx = `SABR_ST_C;
      SABR_X_M: xIdx = `SABR_ST_M;
      default:  xIdx = `SABR_ST_A;
    endcase
  endfunction

  // flag readiness of a branch sitting in stage s; the producer sits dep stages ahead
  function automatic logic flagReady(input sabr_br_t br, input int s,
                                     input sabr_stg_t [`SABR_NSTG-1:0] stg);
    int p;
    p = s + int'(br.dep);
    case (br.kind)
      SABR_BR_UNC: flagReady = 1'b1;
      SABR_BR_OLD: flagReady = 1'b1;
      SABR_BR_ALU: begin
        // flag exists the cycle after the producer's own alu stage
        if (p >= `SABR_ST_GONE) begin
          flagReady = 1'b1;
        end else begin
          flagReady = p > xIdx(stg[p].xPos);
        end
      end
      SABR_BR_CRL: flagReady = p >= `SABR_ST_W;
      SABR_BR_CTR: flagReady = p >= `SABR_ST_GONE;
      default:     flagReady = 1'b1;
    endcase
  endfunction

  // find the oldest unresolved branch: highest stage first, then lowest slot
  always_comb begin
    fnd   = 1'b0;
    selS  = 0;
    selB  = 0;
    for (int s = `SABR_NSTG - 1; s >= 0; s--) begin
      for (int b = 0; b < `SABR_NBR; b++) begin
        if (!fnd && st.stg[s].vld && st.stg[s].br[b].vld && !st.stg[s].done[b]) begin
          fnd  = 1'b1;
          selS = s;
          selB = b;
        end
      end
    end
    selBr = st.stg[selS].br[selB];
    // a younger branch never gets a turn while the oldest waits
    rdy   = fnd && flagReady(selBr, selS, st.stg);
    // decided here, ahead of the alu slide, so its next position never loops back into it
    // unconditional branches are always taken; only the target is in doubt
    resNow  = rdy;
    taken   = rdy && ((selBr.kind == SABR_BR_UNC)
           || condTrue[selS * `SABR_NBR + selB]);
    missNow = rdy && ((taken != selBr.predTaken)
           || (taken && (selBr.realTgt != selBr.predTgt)));
  end

  // resolve, flush and advance
  always_comb begin
    nxt           = st;
    nxt.flush     = 1'b0;
    nxt.redir.vld = 1'b0;
    nxt.resVld    = 1'b0;
    nxt.resMiss   = 1'b0;
    if (rdy) begin
      nxt.stg[selS].done[selB] = 1'b1;
      nxt.resVld  = 1'b1;
      nxt.resMiss = missNow;
      if (missNow) begin
        nxt.flush     = 1'b1;
        nxt.redir.vld = 1'b1;
        nxt.redir.pc  = taken ? selBr.realTgt : selBr.seqPc;
        // everything younger than the branch is wrong-path work
        for (int s = 0; s < `SABR_NSTG; s++) begin
          if (s < selS) begin
            nxt.stg[s].vld = 1'b0;
          end
        end
        for (int b = 0; b < `SABR_NBR; b++) begin
          if (b > selB) begin
            nxt.stg[selS].br[b].vld = 1'b0;
          end
        end
      end
    end
    // the stall holds every stage whole, so dep distances stay true
    if (!stall) begin
      for (int s = `SABR_NSTG - 1; s > 0; s--) begin
        nxt.stg[s] = nxt.stg[s - 1];
      end
      nxt.stg[`SABR_ST_A].vld  = issueGrp.vld && !missNow;
      nxt.stg[`SABR_ST_A].xPos = nextLoc;
      nxt.stg[`SABR_ST_A].done = '0;
      nxt.stg[`SABR_ST_A].br   = issueGrp.br;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      for (int s = 0; s < `SABR_NSTG; s++) begin
        st.stg[s].xPos <= SABR_X_A;
      end
    end else begin
      st <= nxt;
    end
  end

  // alu point placement; told of the mispredict in the same cycle
  sabr_alu_slide u_slide (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .hold    (stall),
    .miss    (missNow),
    .grp     (issueGrp),
    .twoIdle (nextTwoNoAlu),
    .loc     (xLoc),
    .nextLoc (nextLoc)
  );

  // outputs straight from state
  assign pipeStages  = st.stg;
  assign flush       = st.flush;
  assign redirect    = st.redir;
  assign resolveVld  = st.resVld;
  assign resolveMiss = st.resMiss;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence sRun;
    !stall && !missNow;
  endsequence

  sequence sRedirect;
    flush && redirect.vld && resolveMiss;
  endsequence

  AST_FLOW: assert property (sRun ##0 st.stg[`SABR_ST_A].vld ##1 sRun [*2]
    |=> st.stg[`SABR_ST_W].vld)
    else $error("group did not reach writeback in three cycles");
  AST_LOCKSTEP: assert property (stall && !resNow |=> $stable(st.stg))
    else $error("stalled groups moved");
  AST_XPOS_TRACK: assert property (sRun ##0 issueGrp.vld |=> st.stg[`SABR_ST_A].xPos == xLoc
    ##1 (!$past(stall) ->
    st.stg[`SABR_ST_C].xPos == $past(st.stg[`SABR_ST_A].xPos)))
    else $error("flow lost its alu position");
  AST_FLAG_WAIT: assert property (resNow && selBr.kind == SABR_BR_ALU
    && (selS + int'(selBr.dep)) < `SABR_ST_GONE
    |-> (selS + int'(selBr.dep)) > xIdx(st.stg[selS + int'(selBr.dep)].xPos))
    else $error("branch resolved before its alu flag existed");
  AST_REDIRECT: assert property (missNow |=> sRedirect ##1 !flush)
    else $error("mispredict without a one-cycle flush and redirect");
  AST_GOOD_QUIET: assert property (resNow && !missNow |=> resolveVld && !flush)
    else $error("correct prediction flushed");
  AST_UNC_NOWAIT: assert property (fnd && selBr.kind == SABR_BR_UNC |-> resNow)
    else $error("unconditional branch waited");
  AST_OLD_IN_A: assert property (fnd && selBr.kind == SABR_BR_OLD |-> resNow)
    else $error("stale-flag branch did not resolve");
  AST_ONE_OLDEST: assert property (fnd && !rdy |=> !resolveVld)
    else $error("younger branch resolved ahead of a waiting one");
  AST_CRL_LATE: assert property (resNow && selBr.kind == SABR_BR_CRL
    |-> (selS + int'(selBr.dep)) >= `SABR_ST_W)
    else $error("condition logical flag used before writeback");
  AST_CTR_LATE: assert property (resNow && selBr.kind == SABR_BR_CTR
    |-> (selS + int'(selBr.dep)) >= `SABR_ST_GONE)
    else $error("count branch resolved before count load left writeback");
  AST_MISS_KILL: assert property (missNow && selS > `SABR_ST_A
    |=> !st.stg[`SABR_ST_A].vld || stall)
    else $error("younger group survived a flush");

endmodule // sabr_pipe_ctrl

// ### sabr_pipe_ctrl_tb.sv
// sabr_pipe_ctrl_tb.sv: self-checking bench for the sliding alu and branch resolve control
// assumes: sabr_fetch_model offers groups; the bench drives stall, lookahead and conditions
`timescale 1ns/1ps
`include "sabr_defs.svh"
`define SABR_CMP(act, exp) begin checks++; if ((act) !== (exp)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (act), (exp)); end end

module sabr_pipe_ctrl_tb import sabr_pkg::*; ;
  logic                            sys_clk;
  logic                            rst_b;
  logic                            stall;
  logic                            nextTwoNoAlu;
  logic [`SABR_NSTG*`SABR_NBR-1:0] condTrue;
  sabr_grp_t                       reqGrp;
  sabr_grp_t                       issueGrp;
  sabr_stg_t [`SABR_NSTG-1:0]      pipeStages;
  sabr_xloc_t                      xLoc;
  logic                            flush;
  sabr_redir_t                     redirect;
  logic                            resolveVld;
  logic                            resolveMiss;
  logic [`SABR_PCW-1:0]            fetchPc;
  int                              bad_count = 0;
  int                              checks = 0;

  sabr_pipe_ctrl DUT (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .stall        (stall),
    .issueGrp     (issueGrp),
    .nextTwoNoAlu (nextTwoNoAlu),
    .condTrue     (condTrue),
    .pipeStages   (pipeStages),
    .xLoc         (xLoc),
    .flush        (flush),
    .redirect     (redirect),
    .resolveVld   (resolveVld),
    .resolveMiss  (resolveMiss)
  );

  sabr_fetch_model fetchModel (
    .sys_clk  (sys_clk),
    .redirect (redirect),
    .rst_b    (rst_b),
    .reqGrp   (reqGrp),
    .issueGrp (issueGrp),
    .fetchPc  (fetchPc)
  );

  // 25 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // branch with random addresses; tgtBad makes the predicted target wrong
  function automatic sabr_br_t mkBr(sabr_brk_t k, logic [1:0] d, logic pt, logic tgtBad);
    sabr_br_t b;
    b = '0;
    b.vld = 1'b1;
    b.kind = k;
    b.dep = d;
    b.predTaken = pt;
    b.predTgt = `SABR_PCW'($urandom);
    b.realTgt = b.predTgt ^ (`SABR_PCW'(tgtBad) << 2);
    b.seqPc = `SABR_PCW'($urandom);
    return b;
  endfunction

  // code bits: 0 vld, 1 alu, 2 load use prev, 3 load use same, 4 spr move, 5 compare
  function automatic sabr_grp_t mkGrp(logic [7:0] c, sabr_br_t b0, sabr_br_t b1);
    sabr_grp_t g;
    g = '0;
    g.vld = c[0];
    g.aluUse = c[1];
    g.loadUsePrev = c[2];
    g.loadUseSame = c[3];
    g.sprMove = c[4];
    g.cmpRec = c[5];
    g.br[0] = b0;
    g.br[1] = b1;
    return g;
  endfunction

  function automatic logic expMiss(sabr_br_t b, logic c);
    logic tk;
    tk = (b.kind == SABR_BR_UNC) ? 1'b1 : c;
    return (tk != b.predTaken) || (tk && (b.predTgt != b.realTgt));
  endfunction

  function automatic logic [`SABR_PCW-1:0] expPc(sabr_br_t b, logic c);
    return (b.kind == SABR_BR_UNC || c) ? b.realTgt : b.seqPc;
  endfunction

  // one clock: group is latched by the model at the falling edge, other inputs driven there;
  // c bit 7 is stall and bit 6 the two-flow lookahead
  task automatic cyc(sabr_grp_t g, logic [7:0] c, logic [7:0] ct);
    reqGrp = g;
    @(negedge sys_clk);
    stall = c[7];
    nextTwoNoAlu = c[6];
    condTrue = ct;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic idle(int n);
    repeat (n) cyc(mkGrp(8'h00, '0, '0), 8'h00, 8'h00);
  endtask

  task automatic done(string s);
    $display("test %s finished, checks=%0d bad_count=%0d", s, checks, bad_count);
  endtask

  // lone branch in slot 0; expK counts edges after issue until the resolve pulse
  task automatic brCase(sabr_br_t b, logic [7:0] c, logic cv, int expK);
    int k;
    logic [7:0] ct;
    ct = {4{1'b0, cv}};
    k = 0;
    cyc(mkGrp(c, b, '0), 8'h00, ct);
    for (int i = 1; i <= 6 && k == 0; i++) begin
      cyc(mkGrp(8'h00, '0, '0), 8'h00, ct);
      if (resolveVld === 1'b1) begin
        k = i;
        `SABR_CMP(resolveMiss, expMiss(b, cv))
        `SABR_CMP(flush, expMiss(b, cv))
        `SABR_CMP(redirect.vld, expMiss(b, cv))
        if (expMiss(b, cv)) begin
          `SABR_CMP(redirect.pc, expPc(b, cv))
          `SABR_CMP(xLoc, SABR_X_A)
        end
      end
    end
    // penalty is expK plus one, so 2 when known in address up to 5 from memory
    `SABR_CMP(k, expK)
    idle(6);
    if (expMiss(b, cv)) `SABR_CMP(fetchPc, expPc(b, cv))
  endtask

  // two groups back to back; slot 1 condition true, slot 0 false in every stage
  task automatic pairRun(sabr_grp_t g0, sabr_grp_t g1, logic [5:0] expV, logic [5:0] expM);
    logic [5:0] v;
    logic [5:0] m;
    cyc(g0, 8'h00, 8'haa);
    for (int i = 0; i < 6; i++) begin
      cyc((i == 0) ? g1 : mkGrp(8'h00, '0, '0), 8'h00, 8'haa);
      v[i] = resolveVld;
      m[i] = resolveMiss;
    end
    `SABR_CMP(v, expV)
    `SABR_CMP(m, expM)
    idle(4);
  endtask

  // alu point walk: expected place after each group or idle cycle
  logic [7:0] slCode [13] = '{8'h07, 8'h03, 8'h01, 8'h0b, 8'h07, 8'h03, 8'h01,
                              8'h13, 8'h40, 8'h33, 8'h07, 8'h80, 8'h00};
  sabr_xloc_t slExp [13] = '{SABR_X_C, SABR_X_C, SABR_X_A, SABR_X_M, SABR_X_M, SABR_X_M,
                             SABR_X_C, SABR_X_M, SABR_X_A, SABR_X_A, SABR_X_C, SABR_X_C,
                             SABR_X_A};
  int posT [6] = '{0, 1, 1, 2, 3, 4};

  initial begin
    sabr_br_t b;
    rst_b = 1'b0;
    stall = 1'b0;
    nextTwoNoAlu = 1'b0;
    condTrue = 8'h00;
    reqGrp = '0;
    void'($urandom(32'hab613b1b));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    idle(1);
    `SABR_CMP(xLoc, SABR_X_A)
    `SABR_CMP({flush, resolveVld, pipeStages[0].vld}, 3'h0)
    done("reset");
    for (int i = 0; i < 13; i++) begin
      cyc(mkGrp(slCode[i], '0, '0), slCode[i], 8'h00);
      `SABR_CMP(xLoc, slExp[i])
    end
    done("slide");
    // the slide groups must drain, or the walk sees them in the later stages
    idle(4);
    // one cycle of stall while the group sits in cache must hold it there
    cyc(mkGrp(8'h07, '0, '0), 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      if (i > 0) cyc(mkGrp(8'h00, '0, '0), (i == 2) ? 8'h80 : 8'h00, 8'h00);
      for (int s = 0; s < 4; s++) `SABR_CMP(pipeStages[s].vld, 1'(s == posT[i]))
      if (posT[i] < 4) `SABR_CMP(pipeStages[posT[i]].xPos, SABR_X_C)
    end
    idle(3);
    done("walk");
    brCase(mkBr(SABR_BR_OLD, 2'h0, 1'b0, 1'b0), 8'h01, 1'b1, 1);
    brCase(mkBr(SABR_BR_UNC, 2'h0, 1'b1, 1'b1), 8'h01, 1'b0, 1);
    brCase(mkBr(SABR_BR_ALU, 2'h0, 1'b1, 1'b0), 8'h03, 1'b0, 2);
    brCase(mkBr(SABR_BR_ALU, 2'h0, 1'b0, 1'b0), 8'h07, 1'b1, 3);
    brCase(mkBr(SABR_BR_ALU, 2'h0, 1'b0, 1'b0), 8'h0b, 1'b1, 4);
    brCase(mkBr(SABR_BR_CRL, 2'h0, 1'b1, 1'b0), 8'h01, 1'b1, 4);
    brCase(mkBr(SABR_BR_CRL, 2'h2, 1'b0, 1'b0), 8'h01, 1'b1, 2);
    brCase(mkBr(SABR_BR_CTR, 2'h1, 1'b0, 1'b0), 8'h01, 1'b1, 4);
    done("branch kinds");
    pairRun(mkGrp(8'h01, mkBr(SABR_BR_OLD, 2'h0, 1'b0, 1'b0), mkBr(SABR_BR_OLD, 2'h0, 1'b0, 1'b0)),
            mkGrp(8'h00, '0, '0), 6'h03, 6'h02);
    pairRun(mkGrp(8'h0b, mkBr(SABR_BR_ALU, 2'h0, 1'b0, 1'b0), '0),
            mkGrp(8'h01, '0, mkBr(SABR_BR_OLD, 2'h0, 1'b0, 1'b0)), 6'h18, 6'h10);
    done("oldest first");
    for (int n = 0; n < 16; n++) begin
      b = mkBr(($urandom % 2) ? SABR_BR_OLD : SABR_BR_UNC, 2'h0, 1'($urandom), 1'($urandom));
      brCase(b, 8'h01, 1'($urandom), 1);
    end
    done("random");
    summarize();
  end

  // the whole run needs well under 600 cycles; give it 3000
  initial begin
    #120000;
    bad_count++;
    summarize();
  end

  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
endmodule // sabr_pipe_ctrl_tb

// ### sabr_pkg.sv
// sabr_pkg.sv: types shared by the sliding alu and branch resolve logic
// assumes: sabr_defs.svh sits beside this file
`include "sabr_defs.svh"

package sabr_pkg;

  // position of the alu execution point, one-hot
  typedef enum logic [2:0] {
    SABR_X_A = 3'h1,
    SABR_X_C = 3'h2,
    SABR_X_M = 3'h4
  } sabr_xloc_t;

  // what a branch waits for before it can resolve
  typedef enum logic [2:0] {
    SABR_BR_UNC = 3'h0, // unconditional: target check only
    SABR_BR_OLD = 3'h1, // flag not recently written
    SABR_BR_ALU = 3'h2, // flag from an alu instruction
    SABR_BR_CRL = 3'h3, // flag from a condition logical op
    SABR_BR_CTR = 3'h4  // count test after an explicit count load
  } sabr_brk_t;

  typedef struct packed {
    logic                 vld;
    sabr_brk_t            kind;
    logic [1:0]           dep;       // stages the flag producer runs ahead
    logic                 predTaken;
    logic [`SABR_PCW-1:0] predTgt;
    logic [`SABR_PCW-1:0] realTgt;
    logic [`SABR_PCW-1:0] seqPc;     // fall-through address
  } sabr_br_t;

  typedef struct packed {
    logic                        vld;
    logic                        aluUse;
    logic                        loadUsePrev; // uses a load of the previous group
    logic                        loadUseSame; // uses a load of its own group
    logic                        sprMove;     // special_register or whole condition move
    logic                        cmpRec;      // compare or record_bit field update
    sabr_br_t [`SABR_NBR-1:0]    br;
  } sabr_grp_t;

  typedef struct packed {
    logic                        vld;
    sabr_xloc_t                  xPos;
    logic [`SABR_NBR-1:0]        done;
    sabr_br_t [`SABR_NBR-1:0]    br;
  } sabr_stg_t;

  typedef struct packed {
    logic                 vld;
    logic [`SABR_PCW-1:0] pc;
  } sabr_redir_t;

  typedef struct packed {
    sabr_stg_t [`SABR_NSTG-1:0] stg;
    logic                       flush;
    sabr_redir_t                redir;
    logic                       resVld;
    logic                       resMiss;
  } sabr_ctl_t;

  typedef struct packed {
    sabr_xloc_t loc;
  } sabr_sld_t;

endpackage
